// >>> include/sdpi_pkg.sv
// Contract
// - Reset input is active low and asynchronous
// - Hard reset starts on power-good rising edge
// - Drive system reset output to other components
// - Latch data pins 20..0 into straps
// - Shared pin: chip select, address 12 or bank 1
// - Row then column on shared address lines
// - Chip selects enable or mask the memories
// - 64-bit data; half bank holds upper half high
// - Four active-low row strobes, one per bank
// - Row strobes driven and read back
// - Eight active-low column strobes, one per lane
// - Column strobes driven and read back
// - One write enable: high read, low write
// - Controller steps on the memory clock input
// - Generate the memory clock output internally
// - Host transactions arrive from the host clock
package sdpi_pkg;

	// Reference clock rate and reset stretch time.
	localparam int unsigned REF_CLK_MHZ    = 50;
	localparam int unsigned RST_HOLD_NS    = 1000;
	localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_CNT_W      = 8;
	localparam logic [7:0]  RST_CNT_LOAD   = 8'(RST_HOLD_CYC);

	// Bus widths.
	localparam int unsigned DATA_W  = 64;
	localparam int unsigned HALF_W  = 32;
	localparam int unsigned STRAP_W = 21;
	localparam int unsigned ADDR_W  = 11;
	localparam int unsigned ROW_W   = 12;
	localparam int unsigned BANKS   = 4;
	localparam int unsigned LANES   = 8;

	// Strap field positions.
	localparam int unsigned STRAP_DENS_LSB = 0;
	localparam int unsigned STRAP_BANK4    = 2;
	localparam int unsigned STRAP_HALF     = 3;

	// Part density codes held in the straps.
	localparam logic [1:0] DENS_16M  = 2'h0;
	localparam logic [1:0] DENS_64M  = 2'h1;
	localparam logic [1:0] DENS_128M = 2'h2;

	// Reset values.
	localparam logic [STRAP_W-1:0] STRAP_RST = 21'h000000;
	localparam logic [DATA_W-1:0]  DATA_RST  = 64'h0000000000000000;

	// A host request, held stable by the host until it is acknowledged.
	typedef struct packed {
		logic                write;
		logic [1:0]          chip;
		logic [1:0]          bank;
		logic [ROW_W-1:0]    row;
		logic [ADDR_W-1:0]   col;
		logic [LANES-1:0]    lane_en;
		logic [DATA_W-1:0]   wdata;
	} sdpi_req_t;

	// Access sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACT  = 2'b01,
		ST_RW   = 2'b10,
		ST_DONE = 2'b11
	} sdpi_state_t;

endpackage

// >>> logic/sdpi_top.sv
`timescale 1ns/1ps
module sdpi_top
	import sdpi_pkg::*;
(
	input  wire logic                 REF_CLK,
	input  wire logic                 NRST,
	input  wire logic                 CE,
	input  wire logic                 SYSTEM_RESET_IN_N,
	output logic                      SYSTEM_RESET_OUT_N,
	output logic [STRAP_W-1:0]        STRAP_REGISTERS,
	input  wire logic                 MEMORY_CLOCK_IN,
	output logic                      MEMORY_CLOCK_OUT,
	input  wire logic                 HOST_REQ_TGL,
	input  wire sdpi_req_t            HOST_REQ,
	output logic                      HOST_ACK_TGL,
	output logic [DATA_W-1:0]         HOST_RDATA,
	output logic [2:0]                CHIP_SEL_N,
	output logic                      SHARED_CS3_A12_BA1,
	output logic                      BANK_ADDR0,
	output logic [ADDR_W-1:0]         MEM_ROW_COL_ADDR,
	output logic [BANKS-1:0]          ROW_STROBE_N_O,
	output logic                      ROW_STROBE_N_OE,
	input  wire logic [BANKS-1:0]     ROW_STROBE_N_I,
	output logic [LANES-1:0]          COL_STROBE_N_O,
	output logic                      COL_STROBE_N_OE,
	input  wire logic [LANES-1:0]     COL_STROBE_N_I,
	output logic                      MEM_WRITE_EN_N,
	output logic [DATA_W-1:0]         MEM_DATA_O,
	output logic [DATA_W-1:0]         MEM_DATA_OE,
	input  wire logic [DATA_W-1:0]    MEM_DATA_I,
	output logic                      STROBE_MISMATCH
);

	// Synchroniser stages for every input from outside the reference clock except HOST_REQ, which is captured directly.
	logic [1:0]            pg_sync_q, pg_sync_d;           // Power-good / reset input.
	logic                  pg_prev_q, pg_prev_d;           // Last settled power-good level.
	logic [1:0]            mck_sync_q, mck_sync_d;         // Memory clock input.
	logic                  mck_prev_q, mck_prev_d;         // Last settled memory clock level.
	logic [1:0]            req_sync_q, req_sync_d;         // Host request toggle.
	logic                  req_prev_q, req_prev_d;         // Toggle level already served.
	logic [BANKS-1:0]      ras_s1_q, ras_s2_q;             // Row strobe readback.
	logic [LANES-1:0]      cas_s1_q, cas_s2_q;             // Column strobe readback.
	logic [DATA_W-1:0]     md_s1_q, md_s2_q;               // Data pins, for straps and reads.

	// Edge detection taken from the second stage only.
	logic pg_rise;
	logic mck_rise;
	logic req_new;

	assign pg_rise  = pg_sync_q[1] & ~pg_prev_q;
	assign mck_rise = mck_sync_q[1] & ~mck_prev_q;
	assign req_new  = req_sync_q[1] ^ req_prev_q;

	// Compute the next synchroniser values.
	always_comb begin
		pg_sync_d  = {pg_sync_q[0], SYSTEM_RESET_IN_N};
		pg_prev_d  = pg_sync_q[1];
		mck_sync_d = {mck_sync_q[0], MEMORY_CLOCK_IN};
		mck_prev_d = mck_sync_q[1];
		req_sync_d = {req_sync_q[0], HOST_REQ_TGL};
	end

	// Register the synchronisers; the readback stages are pure flops.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			pg_sync_q  <= 2'h0;
			pg_prev_q  <= 1'h0;
			mck_sync_q <= 2'h0;
			mck_prev_q <= 1'h0;
			req_sync_q <= 2'h0;
			ras_s1_q   <= 4'hF;
			ras_s2_q   <= 4'hF;
			cas_s1_q   <= 8'hFF;
			cas_s2_q   <= 8'hFF;
			md_s1_q    <= DATA_RST;
			md_s2_q    <= DATA_RST;
		end else if (CE) begin
			pg_sync_q  <= pg_sync_d;
			pg_prev_q  <= pg_prev_d;
			mck_sync_q <= mck_sync_d;
			mck_prev_q <= mck_prev_d;
			req_sync_q <= req_sync_d;
			ras_s1_q   <= ROW_STROBE_N_I;
			ras_s2_q   <= ras_s1_q;
			cas_s1_q   <= COL_STROBE_N_I;
			cas_s2_q   <= cas_s1_q;
			md_s1_q    <= MEM_DATA_I;
			md_s2_q    <= md_s1_q;
		end
	end

	// Hard reset sequencer state.
	logic [RST_CNT_W-1:0]  rst_cnt_q, rst_cnt_d;   // Remaining stretch cycles.
	logic                  sys_rst_n_q, sys_rst_n_d; // System reset output level.
	logic [STRAP_W-1:0]    strap_q, strap_d;       // Power-up configuration straps.
	logic                  hard_rst;               // Sequencer held in reset.

	// Low input holds reset; its rising edge loads straps and stretches reset.
	always_comb begin
		rst_cnt_d   = rst_cnt_q;
		strap_d     = strap_q;
		sys_rst_n_d = sys_rst_n_q;
		if (!pg_sync_q[1]) begin
			rst_cnt_d   = RST_CNT_LOAD;
			sys_rst_n_d = 1'b0;
		end else if (pg_rise) begin
			strap_d     = md_s2_q[STRAP_W-1:0];
			rst_cnt_d   = RST_CNT_LOAD;
			sys_rst_n_d = 1'b0;
		end else if (rst_cnt_q != '0) begin
			rst_cnt_d   = rst_cnt_q - 8'h01;
		end else begin
			sys_rst_n_d = 1'b1;
		end
	end

	assign hard_rst = ~sys_rst_n_q;

	// Register the reset sequencer.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rst_cnt_q   <= RST_CNT_LOAD;
			strap_q     <= STRAP_RST;
			sys_rst_n_q <= 1'b0;
		end else if (CE) begin
			rst_cnt_q   <= rst_cnt_d;
			strap_q     <= strap_d;
			sys_rst_n_q <= sys_rst_n_d;
		end
	end

	// Strap decoding.
	logic       dens_16m;   // Shared pin serves as fourth chip select.
	logic       bank4;      // Four internal banks per device.
	logic       half_bank;  // Only the lower data half is fitted.

	assign dens_16m  = strap_q[STRAP_DENS_LSB +: 2] == DENS_16M;
	assign bank4     = strap_q[STRAP_BANK4];
	assign half_bank = strap_q[STRAP_HALF];

	// One-hot active-low select of a single device or bank.
	function automatic logic [3:0] sel_n(input logic [1:0] idx);
		sel_n = ~(4'h1 << idx);
	endfunction

	// Access sequencer and pin state.
	sdpi_state_t           st_q, st_d;             // Sequencer state.
	sdpi_req_t             req_q, req_d;           // Captured host request.
	logic                  ack_q, ack_d;           // Acknowledge toggle.
	logic [DATA_W-1:0]     rdata_q, rdata_d;       // Read data to host.
	logic [2:0]            cs_n_q, cs_n_d;         // Chip selects 0..2.
	logic                  shared_q, shared_d;     // Shared pin level.
	logic                  ba0_q, ba0_d;           // Bank address bit 0.
	logic [ADDR_W-1:0]     addr_q, addr_d;         // Multiplexed address.
	logic [BANKS-1:0]      ras_n_q, ras_n_d;       // Row strobes.
	logic [LANES-1:0]      cas_n_q, cas_n_d;       // Column strobes.
	logic                  we_n_q, we_n_d;         // Write enable.
	logic [DATA_W-1:0]     dout_q, dout_d;         // Data driven out.
	logic [DATA_W-1:0]     doe_q, doe_d;           // Data drive enables.
	logic                  oe_q;                   // Strobe pin enables.
	logic                  mism_q, mism_d;         // Readback mismatch flag.
	logic [BANKS+LANES-1:0] drv1_q, drv1_d;        // Driven strobes, one cycle old.
	logic [BANKS+LANES-1:0] drv2_q, drv2_d;        // Driven strobes, aligned to readback.
	logic [3:0]            cs_all_n;               // Select over four devices.

	assign cs_all_n = sel_n(req_q.chip);

	// Next values of the sequencer; each step waits for a memory clock rise.
	always_comb begin
		st_d     = st_q;
		req_d    = req_q;
		ack_d    = ack_q;
		rdata_d  = rdata_q;
		cs_n_d   = cs_n_q;
		shared_d = shared_q;
		ba0_d    = ba0_q;
		addr_d   = addr_q;
		ras_n_d  = ras_n_q;
		cas_n_d  = cas_n_q;
		we_n_d   = we_n_q;
		dout_d   = dout_q;
		doe_d    = doe_q;
		req_prev_d = req_prev_q;
		// Strobes read back differently from what was driven.
		// The readback lags two flops, so compare against equally delayed drive.
		drv1_d   = {ras_n_q, cas_n_q};
		drv2_d   = drv1_q;
		mism_d   = {ras_s2_q, cas_s2_q} != drv2_q;
		case (st_q)
			ST_IDLE: begin
				if (req_new && mck_rise) begin
					req_d      = HOST_REQ;
					req_prev_d = req_sync_q[1];
					st_d       = ST_ACT;
				end
			end
			ST_ACT: begin
				if (mck_rise) begin
					cs_n_d   = cs_all_n[2:0];
					ba0_d    = req_q.bank[0];
					addr_d   = req_q.row[ADDR_W-1:0];
					ras_n_d  = sel_n(req_q.bank);
					// Shared pin use depends on the fitted parts.
					if (dens_16m) begin
						shared_d = cs_all_n[3];
					end else if (bank4) begin
						shared_d = req_q.bank[1];
					end else begin
						shared_d = req_q.row[ROW_W-1];
					end
					st_d     = ST_RW;
				end
			end
			ST_RW: begin
				if (mck_rise) begin
					ras_n_d = 4'hF;
					addr_d  = req_q.col;
					if (!dens_16m && !bank4) begin
						shared_d = 1'b0;
					end
					cas_n_d = ~req_q.lane_en;
					we_n_d  = ~req_q.write;
					if (req_q.write) begin
						dout_d = req_q.wdata;
						doe_d  = {DATA_W{1'b1}};
						if (half_bank) begin
							dout_d[DATA_W-1:HALF_W] = {HALF_W{1'b1}};
						end
					end
					st_d    = ST_DONE;
				end
			end
			ST_DONE: begin
				if (mck_rise) begin
					rdata_d = md_s2_q;
					if (half_bank) begin
						rdata_d[DATA_W-1:HALF_W] = {HALF_W{1'b1}};
					end
					cs_n_d   = 3'h7;
					shared_d = dens_16m | shared_q;
					cas_n_d  = 8'hFF;
					we_n_d   = 1'b1;
					doe_d    = DATA_RST;
					ack_d    = ~ack_q;
					st_d     = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// Register the sequencer; a hard reset returns every pin to idle.
	always_ff @(posedge REF_CLK) begin
		if (!NRST || (CE && hard_rst)) begin
			st_q       <= ST_IDLE;
			req_q      <= '0;
			// A hard reset marks the current toggle as served and keeps the ack level,
			// so the host sees neither a phantom request nor a phantom completion.
			req_prev_q <= req_sync_q[1] & NRST;
			ack_q      <= ack_q & NRST;
			rdata_q    <= DATA_RST;
			cs_n_q     <= 3'h7;
			shared_q   <= 1'b1;
			ba0_q      <= 1'b0;
			addr_q     <= '0;
			ras_n_q    <= 4'hF;
			cas_n_q    <= 8'hFF;
			we_n_q     <= 1'b1;
			dout_q     <= DATA_RST;
			doe_q      <= DATA_RST;
			mism_q     <= 1'b0;
			drv1_q     <= {(BANKS+LANES){1'b1}};
			drv2_q     <= {(BANKS+LANES){1'b1}};
		end else if (CE) begin
			st_q       <= st_d;
			req_q      <= req_d;
			req_prev_q <= req_prev_d;
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
			cs_n_q     <= cs_n_d;
			shared_q   <= shared_d;
			ba0_q      <= ba0_d;
			addr_q     <= addr_d;
			ras_n_q    <= ras_n_d;
			cas_n_q    <= cas_n_d;
			we_n_q     <= we_n_d;
			dout_q     <= dout_d;
			doe_q      <= doe_d;
			mism_q     <= mism_d;
			drv1_q     <= drv1_d;
			drv2_q     <= drv2_d;
		end
	end

	// Memory clock output divider and strobe pin enables.
	logic mck_out_q, mck_out_d;

	// The divider stands in for the internal clock generator.
	always_comb begin
		mck_out_d = ~mck_out_q;
	end

	// Register the divider; strobe enables rise right after reset.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			mck_out_q <= 1'b0;
			oe_q      <= 1'b0;
		end else if (CE) begin
			mck_out_q <= mck_out_d;
			oe_q      <= 1'b1;
		end
	end

	// Every output comes straight from a flip-flop.
	assign SYSTEM_RESET_OUT_N = sys_rst_n_q;
	assign STRAP_REGISTERS    = strap_q;
	assign MEMORY_CLOCK_OUT   = mck_out_q;
	assign HOST_ACK_TGL       = ack_q;
	assign HOST_RDATA         = rdata_q;
	assign CHIP_SEL_N         = cs_n_q;
	assign SHARED_CS3_A12_BA1 = shared_q;
	assign BANK_ADDR0         = ba0_q;
	assign MEM_ROW_COL_ADDR   = addr_q;
	assign ROW_STROBE_N_O     = ras_n_q;
	assign ROW_STROBE_N_OE    = oe_q;
	assign COL_STROBE_N_O     = cas_n_q;
	assign COL_STROBE_N_OE    = oe_q;
	assign MEM_WRITE_EN_N     = we_n_q;
	assign MEM_DATA_O         = dout_q;
	assign MEM_DATA_OE        = doe_q;
	assign STROBE_MISMATCH    = mism_q;

endmodule

// >>> verif/sdpi_chk.sv
`timescale 1ns/1ps
// Watches the memory pins and reset outputs of the top module.
module sdpi_chk
	import sdpi_pkg::*;
(
	input wire logic                REF_CLK,
	input wire logic                NRST,
	input wire logic                SYSTEM_RESET_IN_N,
	input wire logic                SYSTEM_RESET_OUT_N,
	input wire logic [STRAP_W-1:0]  STRAP_REGISTERS,
	input wire logic                MEMORY_CLOCK_OUT,
	input wire logic                HOST_ACK_TGL,
	input wire logic [BANKS-1:0]    ROW_STROBE_N_O,
	input wire logic                ROW_STROBE_N_OE,
	input wire logic [LANES-1:0]    COL_STROBE_N_O,
	input wire logic                COL_STROBE_N_OE,
	input wire logic                MEM_WRITE_EN_N,
	input wire logic [DATA_W-1:0]   MEM_DATA_OE,
	input wire logic                STROBE_MISMATCH
);
	// Every check runs on the reference clock and pauses while reset is held.
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	AST_RST_IN: assert property ($fell(SYSTEM_RESET_IN_N) |-> ##[1:4] !SYSTEM_RESET_OUT_N)
		else $error("reset output did not follow reset input");
	AST_RST_HOLD: assert property ($rose(SYSTEM_RESET_OUT_N) |-> $past(SYSTEM_RESET_IN_N, 50))
		else $error("reset output released too early");
	AST_STRAP: assert property (!$stable(STRAP_REGISTERS) |-> !SYSTEM_RESET_OUT_N)
		else $error("straps changed outside reset");
	AST_ROW_COL: assert property (!(&COL_STROBE_N_O) |-> &ROW_STROBE_N_O)
		else $error("row and column strobes low together");
	AST_WRITE: assert property (!MEM_WRITE_EN_N |-> !(&COL_STROBE_N_O))
		else $error("write enable low without column strobe");
	AST_DATA_OE: assert property (|MEM_DATA_OE |-> !MEM_WRITE_EN_N)
		else $error("data driven outside a write");
	AST_ROW_ONE: assert property ($onehot0(~ROW_STROBE_N_O))
		else $error("more than one row strobe low");
	AST_OE: assert property ($past(NRST) |-> ROW_STROBE_N_OE && COL_STROBE_N_OE)
		else $error("strobe pins not driven");
	AST_ACK_IDLE: assert property ($changed(HOST_ACK_TGL) |->
		&COL_STROBE_N_O && MEM_WRITE_EN_N && !(|MEM_DATA_OE) && SYSTEM_RESET_OUT_N)
		else $error("access ended with pins still active");
	AST_MCLK: assert property ($past(NRST) |-> $changed(MEMORY_CLOCK_OUT))
		else $error("memory clock output stalled");
	AST_MISM: assert property (!STROBE_MISMATCH)
		else $error("strobe readback flagged a mismatch");
endmodule

bind sdpi_top sdpi_chk u_chk (.REF_CLK, .NRST, .SYSTEM_RESET_IN_N, .SYSTEM_RESET_OUT_N,
	.STRAP_REGISTERS, .MEMORY_CLOCK_OUT, .HOST_ACK_TGL, .ROW_STROBE_N_O, .ROW_STROBE_N_OE,
	.COL_STROBE_N_O, .COL_STROBE_N_OE, .MEM_WRITE_EN_N, .MEM_DATA_OE, .STROBE_MISMATCH);

// >>> verif/sdpi_dimm.sv
`timescale 1ns/1ps
// Behavioural memory bank: keeps written lanes and answers reads.
module sdpi_dimm
	import sdpi_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               half,
	input  wire logic [STRAP_W-1:0] strap,
	input  wire logic               rst_out_n,
	input  wire logic [ADDR_W-1:0]  addr,
	input  wire logic [BANKS-1:0]   ras_n,
	input  wire logic [LANES-1:0]   cas_n,
	input  wire logic               we_n,
	input  wire logic [DATA_W-1:0]  dq_o,
	input  wire logic [DATA_W-1:0]  dq_oe,
	output logic [BANKS-1:0]        ras_i,
	output logic [LANES-1:0]        cas_i,
	output logic [DATA_W-1:0]       dq_i
);
	logic [DATA_W-1:0] mem [16];     // Small word store indexed by low column bits.
	logic [DATA_W-1:0] last = '0;    // Last pin value, inverted when nobody drives.
	logic [DATA_W-1:0] pin;          // Level the memory side puts on the data pins.

	// The strobe pins read back what is driven onto them.
	assign ras_i = ras_n;
	assign cas_i = cas_n;

	// Straps during reset, stored word on a read, otherwise a moving pattern.
	always_comb begin
		if (!rst_out_n) pin = DATA_W'(strap);
		else if (!(&cas_n) && we_n) pin = mem[addr[3:0]];
		else pin = ~last;
		if (half) pin[63:32] = 32'hFFFFFFFF;
		dq_i = (dq_o & dq_oe) | (pin & ~dq_oe);
	end

	// Writes store only the lanes whose column strobe is low.
	always @(posedge ref_clk) begin
		last <= dq_i;
		if (!(&cas_n) && !we_n) begin
			for (int i = 0; i < LANES; i++) begin
				if (!cas_n[i]) mem[addr[3:0]][8*i +: 8] <= dq_o[8*i +: 8];
			end
		end
	end
endmodule

// >>> verif/test_sdram_pin_interface_reset.sv
`timescale 1ns/1ps
// Boots the interface with several strap settings and runs host accesses.
module test_sdram_pin_interface_reset;
	import sdpi_pkg::*;
	logic ref_clk = 1'b0, mclk_in = 1'b1, nrst = 1'b0, rst_in_n = 1'b0, tgl = 1'b0, half = 1'b0;
	logic [STRAP_W-1:0] strap = '0;
	sdpi_req_t req = '0;
	logic rst_out_n, mclk_out, ack, shared, ba0, ras_oe, cas_oe, we_n, mism;
	logic [STRAP_W-1:0] straps;
	logic [DATA_W-1:0] rdata, dq_o, dq_oe, dq_i;
	logic [2:0] cs_n;
	logic [ADDR_W-1:0] addr;
	logic [BANKS-1:0] ras_o, ras_i;
	logic [LANES-1:0] cas_o, cas_i;
	int fail_count = 0;
	int checks = 0;

	// Reference clock and an unrelated memory clock.
	always #10 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #80 mclk_in = ~mclk_in;
	end

	sdpi_top u_dut (.REF_CLK(ref_clk), .NRST(nrst), .CE(1'b1), .SYSTEM_RESET_IN_N(rst_in_n),
		.SYSTEM_RESET_OUT_N(rst_out_n), .STRAP_REGISTERS(straps), .MEMORY_CLOCK_IN(mclk_in),
		.MEMORY_CLOCK_OUT(mclk_out), .HOST_REQ_TGL(tgl), .HOST_REQ(req), .HOST_ACK_TGL(ack),
		.HOST_RDATA(rdata), .CHIP_SEL_N(cs_n), .SHARED_CS3_A12_BA1(shared), .BANK_ADDR0(ba0),
		.MEM_ROW_COL_ADDR(addr), .ROW_STROBE_N_O(ras_o), .ROW_STROBE_N_OE(ras_oe),
		.ROW_STROBE_N_I(ras_i), .COL_STROBE_N_O(cas_o), .COL_STROBE_N_OE(cas_oe),
		.COL_STROBE_N_I(cas_i), .MEM_WRITE_EN_N(we_n), .MEM_DATA_O(dq_o), .MEM_DATA_OE(dq_oe),
		.MEM_DATA_I(dq_i), .STROBE_MISMATCH(mism));

	sdpi_dimm u_dimm (.ref_clk(ref_clk), .half(half), .strap(strap), .rst_out_n(rst_out_n),
		.addr(addr), .ras_n(ras_o), .cas_n(cas_o), .we_n(we_n), .dq_o(dq_o), .dq_oe(dq_oe),
		.ras_i(ras_i), .cas_i(cas_i), .dq_i(dq_i));

	// Compares one value and counts the result.
	task automatic chk(input logic [63:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Ends the run when a bounded wait ran out.
	task automatic tmo(input int n, lim);
		if (n >= lim) begin
			fail_count++;
			final_report();
		end
	endtask

	// Pulses the reset input, then times the reset output and reads the straps.
	task automatic boot(input logic [STRAP_W-1:0] s, input logic h);
		int n;
		@(negedge ref_clk);
		rst_in_n = 1'b0;
		strap = s;
		half = h;
		repeat (10) @(negedge ref_clk);
		rst_in_n = 1'b1;
		for (n = 0; n < 100 && rst_out_n !== 1'b1; n++) @(negedge ref_clk);
		tmo(n, 100);
		chk(64'(n >= RST_HOLD_CYC && n <= RST_HOLD_CYC + 4), 64'h1);
		chk(64'(straps), 64'(s));
	endtask

	// One host access, capturing the row and column phases on the pins.
	task automatic acc(input logic w, input logic [1:0] ch, bk, input logic [11:0] rw,
		input logic [10:0] cl, input logic [7:0] ln, input logic [63:0] wd, ex);
		logic [10:0] ra, ca;
		logic [3:0] rs;
		logic [7:0] cs;
		logic [2:0] sel;
		logic sh, we, b0, a0, esh;
		int n;
		@(negedge ref_clk);
		req = '{w, ch, bk, rw, cl, ln, wd};
		tgl = ~tgl;
		a0 = ack;
		for (n = 0; n < 200 && ack === a0; n++) begin
			@(posedge ref_clk);
			#1;
			if (!(&ras_o)) begin
				ra = addr;
				rs = ras_o;
				sh = shared;
				sel = cs_n;
				b0 = ba0;
			end
			if (!(&cas_o)) begin
				ca = addr;
				cs = cas_o;
				we = we_n;
			end
		end
		tmo(n, 200);
		esh = straps[1:0] == DENS_16M ? ch != 2'h3 : straps[STRAP_BANK4] ? bk[1] : rw[11];
		chk(64'(rs), 64'(4'(~(4'h1 << bk))));
		chk(64'(b0), 64'(bk[0]));
		chk(64'(ra), 64'(rw[10:0]));
		chk(64'(ca), 64'(cl));
		chk(64'(cs), 64'(8'(~ln)));
		chk(64'(we), 64'(!w));
		chk(64'(sel), 64'(3'(ch == 2'h3 ? 3'h7 : ~(3'h1 << ch))));
		chk(64'(sh), 64'(esh));
		if (!w) chk(rdata, ex);
	endtask

	// Prints the verdict and stops.
	task automatic final_report();
		if (fail_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Small parts, then four-bank half bank, then two-bank full width.
	initial begin
		repeat (5) @(negedge ref_clk);
		nrst = 1'b1;
		boot(21'h000000, 1'b0);
		acc(1'b1, 2'h3, 2'h2, 12'h800, 11'h005, 8'hFF, 64'h0123456789ABCDEF, 64'h0);
		acc(1'b1, 2'h0, 2'h1, 12'h801, 11'h005, 8'h0F, 64'hFFFFFFFFFFFFFFFF, 64'h0);
		acc(1'b0, 2'h0, 2'h1, 12'h801, 11'h005, 8'hFF, 64'h0, 64'h01234567FFFFFFFF);
		boot(21'h00000D, 1'b1);
		acc(1'b1, 2'h2, 2'h3, 12'h3FF, 11'h7FF, 8'hFF, 64'hA5A5A5A55A5A5A5A, 64'h0);
		acc(1'b0, 2'h2, 2'h1, 12'h3FF, 11'h7FF, 8'hFF, 64'h0, 64'hFFFFFFFF5A5A5A5A);
		boot(21'h000001, 1'b0);
		acc(1'b1, 2'h1, 2'h0, 12'h800, 11'h400, 8'hFF, 64'h1122334455667788, 64'h0);
		acc(1'b0, 2'h1, 2'h0, 12'h000, 11'h400, 8'hFF, 64'h0, 64'h1122334455667788);
		chk(64'(mism), 64'h0);
		final_report();
	end
endmodule
